/* File: logic/fps_supervisor.sv */
// Fuser power supervisor: heater regulation, fuser fault detection, fuser
// identification and life count, and low-voltage supply failure reporting.
// Assumes sensor and current readings come from converters on i_sys_clk;
// board pins are asynchronous and are filtered here.
//
// Design decisions made here: the register offsets and the APB register port.
`include "fps_params.svh"

module fps_supervisor (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire fps_pkg::fps_temps_t i_temps,
  input  wire logic [9:0]         i_heater_current,
  input  wire logic               i_page_done,
  input  wire fps_pkg::fps_pins_t i_pins,
  output logic                    o_heater_drive,
  output logic                    o_relay_close,
  output logic                    o_safety_trip,
  output logic                    o_current_trip,
  output logic                    o_switched_24v_en,
  output logic                    o_switched_5v_en,
  output logic                    o_fuser_fail,
  output logic                    o_lv_supply_fail,
  output logic                    o_end_of_life
);
  import fps_pkg::*;

  // ----------------------------------------------------------------------
  // Pin filtering
  // ----------------------------------------------------------------------
  fps_pins_t pin_s1_r, pin_s2_r, pin_s3_r, pin_r;

  function automatic fps_pins_t agree(fps_pins_t a, fps_pins_t b, fps_pins_t held);
    agree = (a & ~(a ^ b)) | (held & (a ^ b));
  endfunction

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r    <= '0;
    end else begin
      pin_s1_r <= i_pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= agree(pin_s2_r, pin_s3_r, pin_r);
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [5:0]  ctrl_r;
  logic [9:0]  target_r, cur_limit_r, rise_temp_r;
  logic [23:0] rise_time_r, open_time_r, page_limit_r, page_cnt_r;
  logic [15:0] freq_min_r, freq_max_r;
  fps_fuser_faults_t ff_r, ff_set;
  fps_lv_faults_t    lv_r, lv_set;
  logic [1:0]  fuser_type_r;
  logic        volt_class_r;
  logic        wr_en, rd_setup, clear;
  logic        addr_ok;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign clear    = wr_en && addr_ok && paddr == `FPS_OFS_CTRL && pwdata[`FPS_CTRL_CLEAR];
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;

  always_comb begin
    case (paddr)
      `FPS_OFS_CTRL, `FPS_OFS_TARGET, `FPS_OFS_CUR_LIMIT, `FPS_OFS_RISE_TIME,
      `FPS_OFS_RISE_TEMP, `FPS_OFS_OPEN_TIME, `FPS_OFS_FREQ_RANGE,
      `FPS_OFS_PAGE_LIMIT, `FPS_OFS_STATUS, `FPS_OFS_PAGE_COUNT,
      `FPS_OFS_IDENT: addr_ok = 1'b1;
      default:        addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ctrl_r       <= '0;
      target_r     <= `FPS_RST_TARGET;
      cur_limit_r  <= `FPS_RST_CUR_LIMIT;
      rise_time_r  <= `FPS_RST_TIME;
      rise_temp_r  <= `FPS_RST_RISE_TEMP;
      open_time_r  <= `FPS_RST_TIME;
      freq_min_r   <= `FPS_RST_FREQ_MIN;
      freq_max_r   <= `FPS_RST_FREQ_MAX;
      page_limit_r <= `FPS_RST_PAGE_LIMIT;
    end else if (wr_en) begin
      case (paddr)
        `FPS_OFS_CTRL: begin
          ctrl_r <= pwdata[5:0];
          ctrl_r[`FPS_CTRL_CLEAR] <= 1'b0;
        end
        `FPS_OFS_TARGET:     target_r     <= pwdata[9:0];
        `FPS_OFS_CUR_LIMIT:  cur_limit_r  <= pwdata[9:0];
        `FPS_OFS_RISE_TIME:  rise_time_r  <= pwdata[23:0];
        `FPS_OFS_RISE_TEMP:  rise_temp_r  <= pwdata[9:0];
        `FPS_OFS_OPEN_TIME:  open_time_r  <= pwdata[23:0];
        `FPS_OFS_FREQ_RANGE: begin
          freq_min_r <= pwdata[15:0];
          freq_max_r <= pwdata[31:16];
        end
        `FPS_OFS_PAGE_LIMIT: page_limit_r <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle so that it can come from a flop
  // while the slave still answers with no wait state.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        `FPS_OFS_CTRL:       prdata <= {26'h0, ctrl_r};
        `FPS_OFS_TARGET:     prdata <= {22'h0, target_r};
        `FPS_OFS_CUR_LIMIT:  prdata <= {22'h0, cur_limit_r};
        `FPS_OFS_RISE_TIME:  prdata <= {8'h0, rise_time_r};
        `FPS_OFS_RISE_TEMP:  prdata <= {22'h0, rise_temp_r};
        `FPS_OFS_OPEN_TIME:  prdata <= {8'h0, open_time_r};
        `FPS_OFS_FREQ_RANGE: prdata <= {freq_max_r, freq_min_r};
        `FPS_OFS_PAGE_LIMIT: prdata <= {8'h0, page_limit_r};
        `FPS_OFS_STATUS:     prdata <= {21'h0, lv_r, ff_r};
        `FPS_OFS_PAGE_COUNT: prdata <= {8'h0, page_cnt_r};
        `FPS_OFS_IDENT:      prdata <= {28'h0, o_end_of_life, volt_class_r, fuser_type_r};
        default:             prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fuser identification and life
  // ----------------------------------------------------------------------
  logic [3:0] id_dly_r;
  logic       right_closed_d_r, id_sample;

  assign id_sample = (id_dly_r == 4'd1) ||
                     (pin_r.right_door_closed && !right_closed_d_r);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      id_dly_r         <= `FPS_ID_DELAY_CYC;
      right_closed_d_r <= 1'b0;
      fuser_type_r     <= '0;
      volt_class_r     <= 1'b0;
    end else begin
      right_closed_d_r <= pin_r.right_door_closed;
      if (id_dly_r != 4'd0)
        id_dly_r <= id_dly_r - 4'd1;
      if (id_sample) begin
        fuser_type_r <= pin_r.fuser_type_sense;
        volt_class_r <= pin_r.line_voltage_class;
      end
    end
  end

  // The fuse in the unit blows after its first pages, so a fresh unit is only
  // seen at identification; the count must not restart on a later sample.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      page_cnt_r <= '0;
    end else if (id_sample && !pin_r.fresh_unit_sense_n) begin
      page_cnt_r <= '0;
    end else if (i_page_done && page_cnt_r != 24'hffffff) begin
      page_cnt_r <= page_cnt_r + 24'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Rise, open sensor and frequency monitors
  // ----------------------------------------------------------------------
  fps_rise_state_t rise_st_r;
  logic [23:0] rise_cnt_r, open_c_cnt_r, open_e_cnt_r;
  logic [9:0]  rise_base_r;
  logic        motor_d_r, rise_fail, open_c_hit, open_e_hit;
  logic        zc_d_r, freq_fail;
  logic [15:0] period_r;

  assign rise_fail = rise_st_r == FPS_RISE_WAIT && rise_cnt_r >= rise_time_r &&
                     ((i_temps.center < rise_base_r + `FPS_T_RISE_STEP) ||
                      (i_temps.center < rise_temp_r) || (i_temps.edge_a < rise_temp_r) ||
                      (i_temps.edge_b < rise_temp_r));
  assign open_c_hit = open_c_cnt_r >= open_time_r;
  assign open_e_hit = open_e_cnt_r >= open_time_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rise_st_r   <= FPS_RISE_IDLE;
      rise_cnt_r  <= '0;
      rise_base_r <= '0;
      motor_d_r   <= 1'b0;
    end else begin
      motor_d_r <= ctrl_r[`FPS_CTRL_MOTOR_ON];
      case (rise_st_r)
        FPS_RISE_IDLE: begin
          if (ctrl_r[`FPS_CTRL_MOTOR_ON] && !motor_d_r) begin
            rise_st_r   <= FPS_RISE_WAIT;
            rise_cnt_r  <= '0;
            rise_base_r <= i_temps.center;
          end
        end
        FPS_RISE_WAIT: begin
          rise_cnt_r <= rise_cnt_r + 24'd1;
          if (!ctrl_r[`FPS_CTRL_MOTOR_ON])
            rise_st_r <= FPS_RISE_IDLE;
          else if (rise_cnt_r >= rise_time_r)
            rise_st_r <= FPS_RISE_DONE;
        end
        FPS_RISE_DONE: begin
          if (!ctrl_r[`FPS_CTRL_MOTOR_ON])
            rise_st_r <= FPS_RISE_IDLE;
        end
        default: rise_st_r <= FPS_RISE_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      open_c_cnt_r <= '0;
      open_e_cnt_r <= '0;
    end else begin
      if (ctrl_r[`FPS_CTRL_MOTOR_ON] && i_temps.center <= `FPS_T_CENTER_OPEN)
        open_c_cnt_r <= open_c_hit ? open_c_cnt_r : open_c_cnt_r + 24'd1;
      else
        open_c_cnt_r <= '0;
      if (i_temps.edge_a <= `FPS_T_EDGE_OPEN || i_temps.edge_b <= `FPS_T_EDGE_OPEN)
        open_e_cnt_r <= open_e_hit ? open_e_cnt_r : open_e_cnt_r + 24'd1;
      else
        open_e_cnt_r <= '0;
    end
  end

  // The mains period is counted between rising zero crossings; a stalled
  // line saturates the count and fails on the maximum.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      zc_d_r   <= 1'b0;
      period_r <= '0;
    end else begin
      zc_d_r <= pin_r.mains_zero_cross;
      if (pin_r.mains_zero_cross && !zc_d_r)
        period_r <= '0;
      else if (period_r != 16'hffff)
        period_r <= period_r + 16'd1;
    end
  end

  assign freq_fail = (ctrl_r[`FPS_CTRL_STANDBY] || !ctrl_r[`FPS_CTRL_INIT_DONE]) &&
                     ((pin_r.mains_zero_cross && !zc_d_r && period_r < freq_min_r) ||
                      period_r > freq_max_r);

  // ----------------------------------------------------------------------
  // Fault latches
  // ----------------------------------------------------------------------
  logic center_hot, edge_hot, edge_safety, over_current;

  assign center_hot   = i_temps.center >= `FPS_T_CENTER_HIGH;
  assign edge_hot     = i_temps.edge_a >= `FPS_T_EDGE_HIGH || i_temps.edge_b >= `FPS_T_EDGE_HIGH;
  assign edge_safety  = i_temps.edge_a >= `FPS_T_EDGE_SAFETY ||
                        i_temps.edge_b >= `FPS_T_EDGE_SAFETY;
  assign over_current = i_heater_current > cur_limit_r;

  always_comb begin
    ff_set.over_temp     = center_hot || edge_hot;
    ff_set.under_temp    = ctrl_r[`FPS_CTRL_INIT_DONE] &&
                           (i_temps.center <= `FPS_T_CENTER_LOW ||
                            i_temps.edge_a <= `FPS_T_EDGE_LOW ||
                            i_temps.edge_b <= `FPS_T_EDGE_LOW);
    ff_set.abnormal_rise = rise_fail;
    ff_set.open_center   = open_c_hit && ctrl_r[`FPS_CTRL_MOTOR_ON];
    ff_set.open_edge     = open_e_hit;
    ff_set.drive_circuit = freq_fail || over_current;
    ff_set.type_mismatch = (fuser_type_r == 2'b01 && volt_class_r) ||
                           (fuser_type_r == 2'b10 && !volt_class_r);
    lv_set.no_24v         = !pin_r.rail_24v_ok;
    lv_set.sleep_overvolt = ctrl_r[`FPS_CTRL_SLEEP] && pin_r.rail_high;
    lv_set.prot_trip      = pin_r.supply_prot_trip;
    lv_set.ident_fail     = id_dly_r == 4'd0 &&
                            (fuser_type_r == 2'b00 || fuser_type_r == 2'b11);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ff_r <= '0;
      lv_r <= '0;
    end else begin
      ff_r <= ff_set | (clear ? '0 : ff_r);
      lv_r <= lv_set | (clear ? '0 : lv_r);
    end
  end

  // ----------------------------------------------------------------------
  // Heater and rail outputs
  // ----------------------------------------------------------------------
  logic heat_ok;

  assign heat_ok = ctrl_r[`FPS_CTRL_HEAT_EN] && !center_hot && !edge_hot && !edge_safety &&
                   !over_current && ff_set == '0 && ff_r == '0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_heater_drive    <= 1'b0;
      o_relay_close     <= 1'b0;
      o_current_trip    <= 1'b0;
      o_fuser_fail      <= 1'b0;
      o_lv_supply_fail  <= 1'b0;
      o_end_of_life     <= 1'b0;
      o_switched_24v_en <= 1'b0;
      o_switched_5v_en  <= 1'b0;
    end else begin
      o_heater_drive    <= heat_ok && i_temps.center < target_r;
      o_relay_close     <= heat_ok;
      o_current_trip    <= over_current;
      o_fuser_fail      <= (ff_set | ff_r) != '0;
      o_lv_supply_fail  <= (lv_set | lv_r) != '0;
      o_end_of_life     <= page_cnt_r >= page_limit_r;
      o_switched_24v_en <= pin_r.front_door_closed && pin_r.right_door_closed;
      o_switched_5v_en  <= pin_r.front_door_closed && pin_r.right_door_closed;
    end
  end

  // The safety path reads the edge sensors alone, so a fault in the control
  // state cannot keep the relay closed.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn)
      o_safety_trip <= 1'b0;
    else
      o_safety_trip <= edge_safety;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  property p_center_cut;
    center_hot |=> !o_heater_drive && !o_relay_close && o_fuser_fail;
  endproperty
  a_center_cut: assert property (p_center_cut) else $error("center hot did not cut heater");

  property p_edge_fault;
    edge_hot |=> ff_r.over_temp && !o_relay_close;
  endproperty
  a_edge_fault: assert property (p_edge_fault) else $error("edge hot not flagged");

  property p_fault_off;
    ff_r != '0 |-> !o_heater_drive ##1 !o_heater_drive && o_fuser_fail;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("heater on during fault");

  property p_safety;
    edge_safety |=> o_safety_trip && !o_relay_close;
  endproperty
  a_safety: assert property (p_safety) else $error("safety path did not trip");

  property p_current;
    over_current |=> o_current_trip && !o_heater_drive ##0 ff_r.drive_circuit;
  endproperty
  a_current: assert property (p_current) else $error("over current not handled");

  property p_under;
    ctrl_r[`FPS_CTRL_INIT_DONE] && i_temps.center <= `FPS_T_CENTER_LOW |=> ff_r.under_temp;
  endproperty
  a_under: assert property (p_under) else $error("under temperature missed");

  property p_hold;
    ff_r.over_temp && !clear |=> ff_r.over_temp;
  endproperty
  a_hold: assert property (p_hold) else $error("fault dropped without clear");

  property p_no_rail;
    !pin_r.rail_24v_ok |=> o_lv_supply_fail;
  endproperty
  a_no_rail: assert property (p_no_rail) else $error("missing rail not reported");

  property p_doors;
    !pin_r.front_door_closed |=> !o_switched_24v_en && !o_switched_5v_en;
  endproperty
  a_doors: assert property (p_doors) else $error("rails on with door open");

  property p_fresh;
    id_sample && !pin_r.fresh_unit_sense_n |=> page_cnt_r == 24'd0;
  endproperty
  a_fresh: assert property (p_fresh) else $error("fresh unit did not restart count");

  c_heating:   cover property (o_heater_drive ##1 !o_heater_drive);
  c_over_temp: cover property (ff_r.over_temp ##1 clear);
  c_eol:       cover property (!o_end_of_life ##1 o_end_of_life);
  c_ident:     cover property (lv_r.ident_fail);
endmodule

/* File: logic/fps_params.svh */
// Offsets, field positions, reset values and thresholds of the fuser power supervisor.
// Assumes temperatures in whole degrees Celsius and a 100 MHz system clock.
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

`define FPS_OFS_CTRL        8'h00
`define FPS_OFS_TARGET      8'h04
`define FPS_OFS_CUR_LIMIT   8'h08
`define FPS_OFS_RISE_TIME   8'h0c
`define FPS_OFS_RISE_TEMP   8'h10
`define FPS_OFS_OPEN_TIME   8'h14
`define FPS_OFS_FREQ_RANGE  8'h18
`define FPS_OFS_PAGE_LIMIT  8'h1c
`define FPS_OFS_STATUS      8'h20
`define FPS_OFS_PAGE_COUNT  8'h24
`define FPS_OFS_IDENT       8'h28

`define FPS_CTRL_HEAT_EN    0
`define FPS_CTRL_MOTOR_ON   1
`define FPS_CTRL_SLEEP      2
`define FPS_CTRL_INIT_DONE  3
`define FPS_CTRL_CLEAR      4
`define FPS_CTRL_STANDBY    5

`define FPS_RST_TARGET      10'h0b4
`define FPS_RST_CUR_LIMIT   10'h3ff
`define FPS_RST_TIME        24'hffffff
`define FPS_RST_RISE_TEMP   10'h064
`define FPS_RST_FREQ_MIN    16'h0000
`define FPS_RST_FREQ_MAX    16'hffff
`define FPS_RST_PAGE_LIMIT  24'hffffff

`define FPS_T_CENTER_HIGH   10'd230
`define FPS_T_EDGE_HIGH     10'd285
`define FPS_T_EDGE_SAFETY   10'd290
`define FPS_T_CENTER_LOW    10'd120
`define FPS_T_EDGE_LOW      10'd100
`define FPS_T_RISE_STEP     10'd2
`define FPS_T_CENTER_OPEN   10'd12
`define FPS_T_EDGE_OPEN     10'd4

`define FPS_ID_DELAY_CYC    4'd8

`endif

/* File: logic/fps_pkg.sv */
// Types shared by the fuser power supervisor.
// Assumes fps_params.svh for all numeric constants.
package fps_pkg;
  typedef struct packed {
    logic [9:0] center;
    logic [9:0] edge_a;
    logic [9:0] edge_b;
  } fps_temps_t;

  typedef struct packed {
    logic       line_voltage_class;
    logic [1:0] fuser_type_sense;
    logic       fresh_unit_sense_n;
    logic       front_door_closed;
    logic       right_door_closed;
    logic       rail_24v_ok;
    logic       rail_high;
    logic       supply_prot_trip;
    logic       mains_zero_cross;
  } fps_pins_t;

  typedef struct packed {
    logic over_temp;
    logic under_temp;
    logic abnormal_rise;
    logic open_center;
    logic open_edge;
    logic drive_circuit;
    logic type_mismatch;
  } fps_fuser_faults_t;

  typedef struct packed {
    logic no_24v;
    logic sleep_overvolt;
    logic prot_trip;
    logic ident_fail;
  } fps_lv_faults_t;

  typedef enum logic [1:0] {
    FPS_RISE_IDLE  = 2'b00,
    FPS_RISE_WAIT  = 2'b01,
    FPS_RISE_DONE  = 2'b10
  } fps_rise_state_t;
endpackage

/* File: test/fps_fuser_unit_model.sv */
// Behavioural fuser unit: a fresh-unit link that opens after a page count.
// Assumes page pulses on the supervisor clock and an install strobe.
module fps_fuser_unit_model (
  input  wire logic i_sys_clk,
  input  wire logic i_install,
  input  wire logic i_page_done,
  output logic      o_fresh_unit_sense_n
);
  // ------------------------------------------
  // Fusible link
  // ------------------------------------------
  logic [6:0] pages_r;

  always_ff @(posedge i_sys_clk) begin
    if (i_install)
      pages_r <= 7'h0;
    else if (i_page_done && pages_r < 7'h64)
      pages_r <= pages_r + 7'h1;
  end

  // A blown link reads high, as the sense line is pulled up.
  assign o_fresh_unit_sense_n = (pages_r >= 7'h64);
endmodule

/* File: test/fps_supervisor_tb.sv */
// Self-checking bench for the fuser power supervisor.
// Assumes the fuser unit model drives the fresh-unit sense pin.
`include "fps_params.svh"
module fps_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fps_pkg::*;
  // ------------------------------------------
  // Signals
  // ------------------------------------------
  logic        clk = 1'h0;
  logic        rstn;
  logic        psel, penable, pwrite, pready, pslverr, err_v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v, ctrl_v;
  fps_temps_t  temps;
  fps_pins_t   pins, pins_w;
  logic [9:0]  cur;
  logic        pd, inst, fresh_n, hd, rc, st, ct, e24, e5, ff, lf, eol;
  int          err_total = 0;
  int          n_compared = 0;

  always #5 clk = ~clk;
  always_comb begin
    pins_w = pins;
    pins_w.fresh_unit_sense_n = fresh_n;
  end

  fps_supervisor i_fps_supervisor (.i_sys_clk(clk), .i_rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_temps(temps), .i_heater_current(cur),
    .i_page_done(pd), .i_pins(pins_w), .o_heater_drive(hd), .o_relay_close(rc),
    .o_safety_trip(st), .o_current_trip(ct), .o_switched_24v_en(e24),
    .o_switched_5v_en(e5), .o_fuser_fail(ff), .o_lv_supply_fail(lf), .o_end_of_life(eol));
  fps_fuser_unit_model i_fps_fuser_unit_model (.i_sys_clk(clk), .i_install(inst),
    .i_page_done(pd), .o_fresh_unit_sense_n(fresh_n));

  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd_v    = prdata;
    err_v   = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic st_is(input logic [31:0] m, input logic [31:0] e, input string s);
    apb(1'h0, `FPS_OFS_STATUS, 32'h0);
    chk(rd_v & m, e, s);
  endtask
  task automatic norm();
    temps <= '{10'h96, 10'h96, 10'h96};
    cur   <= 10'h0;
    pd    <= 1'h0;
    pins  <= '{1'h0, 2'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  endtask
  task automatic clr(input string s);
    norm();
    cyc(8);
    apb(1'h1, `FPS_OFS_CTRL, ctrl_v | 32'h10);
    cyc(2);
    st_is(32'h7ff, 32'h0, "status held after clear");
    chk({ff, lf}, 2'h0, "fail flags held after clear");
    $display("test %s done", s);
  endtask
  task automatic door();
    pins.right_door_closed <= 1'h0;
    cyc(8);
    chk({e24, e5}, 2'h0, "rails on with door open");
    pins.right_door_closed <= 1'h1;
    cyc(8);
  endtask
  task automatic pages(input int n);
    repeat (n) begin
      pd <= 1'h1;
      @(posedge clk);
      pd <= 1'h0;
      @(posedge clk);
    end
    cyc(2);
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_regs();
    apb(1'h0, `FPS_OFS_TARGET, 32'h0);
    chk(rd_v, 32'h0b4, "target reset value");
    apb(1'h0, 8'h3c, 32'h0);
    chk({err_v, rd_v[0]}, 2'h2, "unmapped read answer");
    $display("test regs done");
  endtask
  task automatic t_heat();
    chk({hd, rc}, 2'h3, "heater off below target");
    temps.center <= 10'hb4;
    cyc(3);
    chk({hd, rc}, 2'h1, "heater on at target");
    clr("heat");
  endtask
  task automatic t_hot();
    temps.center <= `FPS_T_CENTER_HIGH - 10'h1;
    cyc(3);
    chk({rc, ff}, 2'h2, "cut below limit");
    temps.center <= `FPS_T_CENTER_HIGH;
    cyc(3);
    chk({hd, rc, ff}, 3'h1, "no cut at limit");
    st_is(32'h40, 32'h40, "over temp missing");
    temps.center <= 10'h96;
    cyc(3);
    chk({hd, rc, ff}, 3'h1, "fault not held");
    clr("center high");
  endtask
  task automatic t_edge();
    temps.edge_b <= `FPS_T_EDGE_HIGH - 10'h1;
    cyc(3);
    chk(ff, 1'h0, "edge fault early");
    temps.edge_b <= `FPS_T_EDGE_HIGH;
    temps.edge_a <= `FPS_T_EDGE_SAFETY - 10'h1;
    cyc(3);
    chk({ff, st, hd}, 3'h4, "edge fault wrong");
    temps.edge_a <= `FPS_T_EDGE_SAFETY;
    cyc(3);
    chk({st, rc}, 2'h2, "safety path idle");
    clr("edge high");
  endtask
  task automatic t_cur();
    apb(1'h1, `FPS_OFS_CUR_LIMIT, 32'h1f4);
    cur <= 10'h1f4;
    cyc(3);
    chk(ct, 1'h0, "trip at limit");
    cur <= 10'h1f5;
    cyc(3);
    chk({ct, hd, ff}, 3'h5, "no trip above limit");
    st_is(32'h2, 32'h2, "drive fault missing");
    clr("current");
  endtask
  task automatic t_low();
    temps.center <= `FPS_T_CENTER_LOW + 10'h1;
    temps.edge_a <= `FPS_T_EDGE_LOW + 10'h1;
    cyc(3);
    chk(ff, 1'h0, "low fault early");
    temps.edge_a <= `FPS_T_EDGE_LOW;
    cyc(3);
    st_is(32'h20, 32'h20, "low fault missing");
    clr("low");
  endtask
  task automatic t_open();
    temps.edge_b <= `FPS_T_EDGE_OPEN;
    temps.center <= `FPS_T_CENTER_OPEN;
    apb(1'h1, `FPS_OFS_CTRL, 32'hb);
    cyc(8);
    st_is(32'h1c, 32'h0, "open or rise fault early");
    cyc(20);
    st_is(32'h1c, 32'h1c, "open or rise fault missing");
    clr("open");
  endtask
  task automatic t_freq();
    apb(1'h1, `FPS_OFS_FREQ_RANGE, 32'h000a0000);
    apb(1'h1, `FPS_OFS_CTRL, 32'h29);
    cyc(20);
    st_is(32'h2, 32'h2, "frequency fault missing");
    apb(1'h1, `FPS_OFS_FREQ_RANGE, 32'hffff0000);
    clr("frequency");
  endtask
  task automatic t_ident();
    pins.fuser_type_sense <= 2'h3;
    door();
    chk({e24, e5, lf}, 3'h7, "unknown fuser");
    st_is(32'h80, 32'h80, "ident fail missing");
    pins.line_voltage_class <= 1'h1;
    pins.fuser_type_sense <= 2'h1;
    door();
    st_is(32'h1, 32'h1, "mismatch missing");
    chk(ff, 1'h1, "mismatch not reported");
    // Type and class are only taken again at a right door close, so cycle the right door.
    norm();
    cyc(1);
    door();
    clr("ident");
    apb(1'h0, `FPS_OFS_IDENT, 32'h0);
    chk(rd_v & 32'h7, 32'h1, "ident value");
  endtask
  task automatic t_supply();
    pins.rail_24v_ok <= 1'h0;
    pins.rail_high <= 1'h1;
    cyc(8);
    st_is(32'h600, 32'h400, "rail faults wrong");
    chk(lf, 1'h1, "no supply failure");
    apb(1'h1, `FPS_OFS_CTRL, 32'hd);
    pins.supply_prot_trip <= 1'h1;
    cyc(8);
    st_is(32'h700, 32'h700, "sleep or trip fault missing");
    clr("supply");
  endtask
  task automatic t_life();
    apb(1'h1, `FPS_OFS_PAGE_LIMIT, 32'h5);
    // Pages on the old unit give the restart something to clear.
    pages(3);
    inst <= 1'h1;
    cyc(1);
    inst <= 1'h0;
    door();
    apb(1'h0, `FPS_OFS_PAGE_COUNT, 32'h0);
    chk(rd_v, 32'h0, "count kept on new unit");
    pages(4);
    chk(eol, 1'h0, "life ends early");
    pages(1);
    chk(eol, 1'h1, "life end missing");
    pages(95);
    door();
    apb(1'h0, `FPS_OFS_PAGE_COUNT, 32'h0);
    chk(rd_v, 32'h64, "used unit read as new");
    $display("test life done");
  endtask

  // ------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------
  initial begin
    {rstn, psel, penable, pwrite, inst} = 5'h1;
    paddr  = 8'h0;
    pwdata = 32'h0;
    ctrl_v = 32'h9;
    norm();
    cyc(20);
    rstn <= 1'h1;
    @(posedge clk);
    t_regs();
    apb(1'h1, `FPS_OFS_OPEN_TIME, 32'h14);
    apb(1'h1, `FPS_OFS_RISE_TIME, 32'h14);
    inst <= 1'h0;
    clr("reset");
    t_heat();
    t_hot();
    t_edge();
    t_cur();
    t_low();
    t_open();
    t_freq();
    t_ident();
    t_supply();
    t_life();
    report_and_stop();
  end
  initial begin
    cyc(20000);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
